// ===== core/bal_top.sv
/*
 * Byte arithmetic and logic datapath with its working registers, io bit access,
 * status flags and an AXI4-Lite slave that issues commands and exposes state.
 * Assumes one clock and a master with at most one write and one read in flight.
 */
`timescale 1ns/1ps
module bal_top (
	input  wire logic                           aclk,
	input  wire logic                           aresetn,
	input  wire logic [bal_pkg::BAL_AXI_AW-1:0] s_axi_awaddr,
	input  wire logic [2:0]                     s_axi_awprot,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	input  wire logic [bal_pkg::BAL_AXI_DW-1:0] s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	output logic      [1:0]                     s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	input  wire logic [bal_pkg::BAL_AXI_AW-1:0] s_axi_araddr,
	input  wire logic [2:0]                     s_axi_arprot,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	output logic      [bal_pkg::BAL_AXI_DW-1:0] s_axi_rdata,
	output logic      [1:0]                     s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready,
	input  wire logic [bal_pkg::BAL_DW-1:0]     io_evt_set
);
	import bal_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	bal_st_e                st_r;
	bal_cmd_s               cmd_r;
	bal_cmd_s               wcmd;
	bal_flags_s             sreg_r;
	bal_flags_s             fl;
	bal_flags_s             upd;
	bal_flags_s             sreg_nxt;
	logic                   err_r;
	logic [BAL_DW-1:0]      mem_a_q;
	logic [BAL_DW-1:0]      mem_b_q;
	logic [BAL_DW-1:0]      io_q;
	logic [BAL_IDX_W-1:0]   mem_a_addr;
	logic [BAL_IDX_W-1:0]   mem_b_addr;
	logic [BAL_IDX_W-1:0]   mem_waddr;
	logic [BAL_IDX_W-1:0]   io_raddr;
	logic [BAL_IDX_W-1:0]   io_waddr;
	logic [BAL_DW-1:0]      mem_wdata;
	logic [BAL_DW-1:0]      io_wdata;
	logic [BAL_DW-1:0]      res;
	logic [BAL_DW-1:0]      bit_m;
	logic [10:0]            hvcr;
	logic [8:0]             add9;
	logic [16:0]            w17;
	logic [15:0]            word_r;
	logic                   wc_r;
	logic                   wv_r;
	logic                   mem_we;
	logic                   io_we;
	logic                   is_word;
	logic                   is_io;
	logic                   in_exec;
	logic                   upd_en;
	logic                   cmd_ok;
	logic                   wr_take;
	logic                   rd_take;
	bal_sel_e               wsel;
	bal_sel_e               rsel;
	logic                   bvalid_r;
	logic [1:0]             bresp_r;
	logic [1:0]             rd_stage_r;
	logic [BAL_AXI_AW-1:0]  rd_addr_r;
	logic                   rvalid_r;
	logic [BAL_AXI_DW-1:0]  rdata_r;
	logic [1:0]             rresp_r;

	// {half carry, overflow, carry, result}
	function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
		logic [8:0] s;
		logic [4:0] l;
		s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
		l = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		add8 = {l[4], (a[7] & b[7] & ~s[7]) | (~a[7] & ~b[7] & s[7]), s[8], s[7:0]};
	endfunction

	// {half borrow, overflow, borrow, result}
	function automatic logic [10:0] sub8(input logic [7:0] a, input logic [7:0] b, input logic ci);
		logic [8:0] s;
		logic [4:0] l;
		s = {1'b0, a} - {1'b0, b} - {8'h00, ci};
		l = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
		sub8 = {l[4], (a[7] & ~b[7] & ~s[7]) | (~a[7] & b[7] & s[7]), s[8], s[7:0]};
	endfunction

	function automatic bal_sel_e decode(input logic [BAL_AXI_AW-1:0] a);
		decode = SEL_NONE;
		if (a[BAL_AXI_AW-1:7] == BAL_WIN_GPR) begin
			decode = SEL_GPR;
		end else if (a[BAL_AXI_AW-1:7] == BAL_WIN_IO) begin
			decode = SEL_IO;
		end else if ({a[BAL_AXI_AW-1:2], 2'b00} == BAL_A_CMD) begin
			decode = SEL_CMD;
		end else if ({a[BAL_AXI_AW-1:2], 2'b00} == BAL_A_SREG) begin
			decode = SEL_SREG;
		end else if ({a[BAL_AXI_AW-1:2], 2'b00} == BAL_A_STAT) begin
			decode = SEL_STAT;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Storage
	bal_gpr_mem u_gpr (
		.aclk    (aclk),
		.aresetn (aresetn),
		.a_addr  (mem_a_addr),
		.a_data  (mem_a_q),
		.b_addr  (mem_b_addr),
		.b_data  (mem_b_q),
		.we      (mem_we),
		.waddr   (mem_waddr),
		.wdata   (mem_wdata)
	);

	bal_io_bank u_io (
		.aclk    (aclk),
		.aresetn (aresetn),
		.raddr   (io_raddr),
		.rdata   (io_q),
		.we      (io_we),
		.waddr   (io_waddr),
		.wdata   (io_wdata),
		.evt_set (io_evt_set)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Datapath
	assign wcmd    = bal_cmd_s'(s_axi_wdata);
	assign is_word = (cmd_r.op == OP_WORD_PLUS_CONSTANT) || (cmd_r.op == OP_WORD_MINUS_CONSTANT);
	assign is_io   = (cmd_r.op == OP_IO_BIT_SET) || (cmd_r.op == OP_IO_BIT_CLEAR);
	assign in_exec = (st_r == ST_EXEC);
	assign add9    = {1'b0, mem_a_q} + {1'b0, mem_b_q};
	assign bit_m   = BAL_ONE << cmd_r.bitn;
	// Reject undefined codes and io addresses beyond the bit-addressable range
	assign cmd_ok  = (wcmd.op < OP_LAST) && !(((wcmd.op == OP_IO_BIT_SET) || (wcmd.op == OP_IO_BIT_CLEAR)) &&
		(wcmd.io_addr >= BAL_IO_LIMIT));

	// Word pair: low byte at even index, high byte just above
	assign mem_a_addr = (st_r == ST_IDLE) ? rd_addr_r[6:2] : (is_word ? {cmd_r.dst[4:1], 1'b0} : cmd_r.dst);
	assign mem_b_addr = is_word ? {cmd_r.dst[4:1], 1'b1} : cmd_r.src;
	assign io_raddr   = (st_r == ST_IDLE) ? rd_addr_r[6:2] : cmd_r.io_addr[4:0];
	assign w17 = (cmd_r.op == OP_WORD_MINUS_CONSTANT) ?
		{1'b0, mem_b_q, mem_a_q} - {11'h000, cmd_r.imm[BAL_WORD_K_W-1:0]} :
		{1'b0, mem_b_q, mem_a_q} + {11'h000, cmd_r.imm[BAL_WORD_K_W-1:0]};

	always_comb begin
		hvcr = '0;
		res  = BAL_ZERO;
		fl   = sreg_r;
		upd  = BAL_UPD_ARITH;
		case (cmd_r.op)
			OP_ADD:                   hvcr = add8(mem_a_q, mem_b_q, 1'b0);
			OP_ADD_CARRY:             hvcr = add8(mem_a_q, mem_b_q, sreg_r.c);
			OP_SUB:                   hvcr = sub8(mem_a_q, mem_b_q, 1'b0);
			OP_MINUS_CONSTANT:        hvcr = sub8(mem_a_q, cmd_r.imm, 1'b0);
			OP_MINUS_WITH_BORROW:     hvcr = sub8(mem_a_q, mem_b_q, sreg_r.c);
			OP_MINUS_BORROW_CONSTANT: hvcr = sub8(mem_a_q, cmd_r.imm, sreg_r.c);
			OP_TWOS_COMP:             hvcr = sub8(BAL_ZERO, mem_a_q, 1'b0);
			OP_AND:                   upd = BAL_UPD_LOGIC;
			OP_MASK_WITH_CONSTANT:    upd = BAL_UPD_LOGIC;
			OP_OR:                    upd = BAL_UPD_LOGIC;
			OP_MERGE_WITH_CONSTANT:   upd = BAL_UPD_LOGIC;
			OP_BIT_SET_IN_REG:        upd = BAL_UPD_LOGIC;
			OP_BIT_CLEAR_IN_REG:      upd = BAL_UPD_LOGIC;
			OP_EXCLUSIVE_MERGE:       upd = BAL_UPD_LOGIC;
			OP_INC:                   upd = BAL_UPD_LOGIC;
			OP_DEC:                   upd = BAL_UPD_LOGIC;
			OP_ONES_COMP:             upd = BAL_UPD_COMP;
			default:                  upd = BAL_UPD_WORD;
		endcase
		res  = hvcr[7:0];
		fl.h = hvcr[10];
		fl.v = hvcr[9];
		fl.c = hvcr[8];
		case (cmd_r.op)
			OP_AND:                 res = mem_a_q & mem_b_q;
			OP_MASK_WITH_CONSTANT:  res = mem_a_q & cmd_r.imm;
			OP_OR:                  res = mem_a_q | mem_b_q;
			OP_MERGE_WITH_CONSTANT: res = mem_a_q | cmd_r.imm;
			OP_BIT_SET_IN_REG:      res = mem_a_q | cmd_r.imm;
			OP_BIT_CLEAR_IN_REG:    res = mem_a_q & (BAL_ALL_ONES - cmd_r.imm);
			OP_EXCLUSIVE_MERGE:     res = mem_a_q ^ mem_b_q;
			OP_ONES_COMP:           res = BAL_ALL_ONES - mem_a_q;
			OP_INC:                 res = mem_a_q + BAL_ONE;
			OP_DEC:                 res = mem_a_q - BAL_ONE;
			default:                res = hvcr[7:0];
		endcase
		if (upd == BAL_UPD_LOGIC || upd == BAL_UPD_COMP) begin
			fl.v = 1'b0;
			fl.c = 1'b1;
		end
		if (cmd_r.op == OP_INC) begin
			fl.v = (res == BAL_MIN_NEG);
		end
		if (cmd_r.op == OP_DEC) begin
			fl.v = (res == BAL_MAX_POS);
		end
		fl.z = (res == BAL_ZERO);
		fl.n = res[BAL_DW-1];
		if (st_r == ST_WORD_HI) begin
			upd  = BAL_UPD_WORD;
			fl.z = (word_r == {BAL_ZERO, BAL_ZERO});
			fl.n = word_r[15];
			fl.v = wv_r;
			fl.c = wc_r;
		end
		fl.s     = fl.n ^ fl.v;
		sreg_nxt = bal_flags_s'((sreg_r & ~upd) | (fl & upd));
	end

	// Word forms settle their flags in the second cycle
	assign upd_en = (in_exec && !is_word && !is_io) || (st_r == ST_WORD_HI);

	always_comb begin
		mem_we    = 1'b0;
		mem_waddr = cmd_r.dst;
		mem_wdata = res;
		if (in_exec && is_word) begin
			mem_we    = 1'b1;
			mem_waddr = {cmd_r.dst[4:1], 1'b0};
			mem_wdata = w17[7:0];
		end else if (in_exec && !is_io) begin
			mem_we = 1'b1;
		end else if (st_r == ST_WORD_HI) begin
			mem_we    = 1'b1;
			mem_waddr = {cmd_r.dst[4:1], 1'b1};
			mem_wdata = word_r[15:8];
		end else if (wr_take && wsel == SEL_GPR && s_axi_wstrb[0]) begin
			mem_we    = 1'b1;
			mem_waddr = s_axi_awaddr[6:2];
			mem_wdata = s_axi_wdata[BAL_DW-1:0];
		end
	end

	// Whole byte goes back, so flags read as one are cleared by the rewrite
	assign io_we    = (in_exec && is_io) || (wr_take && wsel == SEL_IO && s_axi_wstrb[0]);
	assign io_waddr = in_exec ? cmd_r.io_addr[4:0] : s_axi_awaddr[6:2];
	assign io_wdata = !in_exec ? s_axi_wdata[BAL_DW-1:0] :
		(cmd_r.op == OP_IO_BIT_SET) ? (io_q | bit_m) : (io_q & ~bit_m);

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer and state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= ST_IDLE;
		end else begin
			case (st_r)
				ST_IDLE:    st_r <= (wr_take && wsel == SEL_CMD && s_axi_wstrb == BAL_STRB_ALL && cmd_ok) ?
					ST_FETCH : ST_IDLE;
				ST_FETCH:   st_r <= ST_EXEC;
				ST_EXEC:    st_r <= is_word ? ST_WORD_HI : ST_IDLE;
				ST_WORD_HI: st_r <= ST_IDLE;
				default:    st_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_r <= '0;
			err_r <= 1'b0;
		end else if (wr_take && wsel == SEL_CMD && s_axi_wstrb == BAL_STRB_ALL) begin
			cmd_r <= wcmd;
			err_r <= !cmd_ok;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			word_r <= '0;
			wc_r   <= 1'b0;
			wv_r   <= 1'b0;
		end else if (in_exec && is_word) begin
			word_r <= w17[15:0];
			wc_r   <= w17[16];
			wv_r   <= (cmd_r.op == OP_WORD_MINUS_CONSTANT) ? (mem_b_q[7] & ~w17[15]) : (~mem_b_q[7] & w17[15]);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sreg_r <= BAL_FLAGS_RST;
		end else if (upd_en) begin
			sreg_r <= sreg_nxt;
		end else if (wr_take && wsel == SEL_SREG && s_axi_wstrb[0]) begin
			sreg_r <= bal_flags_s'(s_axi_wdata[5:0]);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave; accesses wait while a command runs
	assign wsel    = decode(s_axi_awaddr);
	assign rsel    = decode(rd_addr_r);
	assign wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_r && st_r == ST_IDLE && rd_stage_r == 2'b00 &&
		!rvalid_r;
	assign rd_take = s_axi_arvalid && !wr_take && rd_stage_r == 2'b00 && !rvalid_r && st_r == ST_IDLE &&
		!(s_axi_awvalid && s_axi_wvalid);
	assign s_axi_awready = wr_take;
	assign s_axi_wready  = wr_take;
	assign s_axi_arready = rd_take;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= BAL_RESP_OKAY;
		end else if (wr_take) begin
			bvalid_r <= 1'b1;
			bresp_r  <= (wsel == SEL_NONE) ? BAL_RESP_SLVERR : BAL_RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Storage reads are registered, so data is gathered two edges after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_stage_r <= 2'b00;
			rd_addr_r  <= '0;
			rvalid_r   <= 1'b0;
			rdata_r    <= '0;
			rresp_r    <= BAL_RESP_OKAY;
		end else begin
			rd_stage_r <= {rd_stage_r[0], rd_take};
			if (rd_take) begin
				rd_addr_r <= s_axi_araddr;
			end
			if (rd_stage_r[1]) begin
				rvalid_r <= 1'b1;
				rresp_r  <= (rsel == SEL_NONE) ? BAL_RESP_SLVERR : BAL_RESP_OKAY;
				case (rsel)
					SEL_CMD:  rdata_r <= cmd_r;
					SEL_SREG: rdata_r <= {26'h0, sreg_r};
					SEL_STAT: rdata_r <= {30'h0, err_r, st_r != ST_IDLE};
					SEL_GPR:  rdata_r <= {24'h000000, mem_a_q};
					SEL_IO:   rdata_r <= {24'h000000, io_q};
					default:  rdata_r <= '0;
				endcase
			end else if (s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	a_add_carry_out: assert property (@(posedge aclk) disable iff (!aresetn)
		(in_exec && cmd_r.op == OP_ADD) |-> mem_we && mem_wdata == add9[7:0] ##1 sreg_r.c == $past(add9[8]))
		else $error("add result or carry wrong");
	a_word_two_cycles: assert property (@(posedge aclk) disable iff (!aresetn)
		(in_exec && is_word) |=> st_r == ST_WORD_HI && mem_we ##1 st_r == ST_IDLE)
		else $error("word form not two cycles");
	a_word_sign_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_r == ST_WORD_HI) |=> sreg_r.s == (sreg_r.n ^ sreg_r.v) && sreg_r.z == ($past(word_r) == 16'h0000))
		else $error("word flags wrong");
	a_sub_store: assert property (@(posedge aclk) disable iff (!aresetn)
		(in_exec && cmd_r.op == OP_SUB) |-> mem_we && mem_waddr == cmd_r.dst && mem_wdata == mem_a_q - mem_b_q)
		else $error("subtract stored wrong");
	a_borrow_store: assert property (@(posedge aclk) disable iff (!aresetn)
		(in_exec && cmd_r.op == OP_MINUS_WITH_BORROW) |-> mem_wdata == mem_a_q - mem_b_q - {7'h00, sreg_r.c})
		else $error("borrow subtract wrong");
	a_borrow_const: assert property (@(posedge aclk) disable iff (!aresetn)
		(in_exec && cmd_r.op == OP_MINUS_BORROW_CONSTANT) |-> mem_wdata == mem_a_q - cmd_r.imm - {7'h00, sreg_r.c})
		else $error("constant borrow subtract wrong");
	a_and_keeps_c: assert property (@(posedge aclk) disable iff (!aresetn)
		(in_exec && cmd_r.op == OP_AND) |=> sreg_r.c == $past(sreg_r.c) && !sreg_r.v)
		else $error("logical and touched carry");
	a_clear_bits: assert property (@(posedge aclk) disable iff (!aresetn)
		(in_exec && cmd_r.op == OP_BIT_CLEAR_IN_REG) |-> mem_wdata == (mem_a_q & ~cmd_r.imm))
		else $error("bit clear wrong");
	a_io_rmw_byte: assert property (@(posedge aclk) disable iff (!aresetn)
		(in_exec && cmd_r.op == OP_IO_BIT_SET) |-> io_we && io_wdata == (io_q | bit_m))
		else $error("io bit set not whole-byte rewrite");
	a_io_range: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_take && wsel == SEL_CMD && (wcmd.op == OP_IO_BIT_SET || wcmd.op == OP_IO_BIT_CLEAR) &&
		wcmd.io_addr >= BAL_IO_LIMIT) |=>
		st_r == ST_IDLE && err_r)
		else $error("io address out of range accepted");
	a_inc_keeps_c: assert property (@(posedge aclk) disable iff (!aresetn)
		(in_exec && (cmd_r.op == OP_INC || cmd_r.op == OP_DEC)) |=> sreg_r.c == $past(sreg_r.c))
		else $error("increment or decrement changed carry");

endmodule

// ===== core/bal_pkg.sv
/*
 * Shared constants, types and register map of the byte arithmetic and logic datapath.
 * Assumes one clock domain and an AXI4-Lite master that drives the command register.
 */
// Overview of operation
// - Add or add-with-carry, flags ZCNVH, one cycle
// - Word add constant to pair, ZCNVS, two cycles
// - Word subtract constant from pair, ZCNVS, two cycles
// - Subtract register or constant, ZCNVH, one cycle
// - Register minus source minus carry, ZCNVH
// - Register minus constant minus carry, ZCNVH
// - AND with register or constant, carry kept
// - OR with register or constant, ZNV
// - Set bits: OR with constant mask
// - Clear bits: AND with all-ones minus mask
// - Some io flags clear on written one
// - Io bit set/clear rewrites whole byte
// - Io bit operations reach addresses 0x00-0x1F only
package bal_pkg;

	localparam int          BAL_DW           = 8;
	localparam int          BAL_IDX_W        = 5;
	localparam int          BAL_AXI_AW       = 12;
	localparam int          BAL_AXI_DW       = 32;
	localparam int          BAL_WORD_K_W     = 6;
	localparam logic [7:0]  BAL_ALL_ONES     = 8'hff;
	localparam logic [7:0]  BAL_ZERO         = 8'h00;
	localparam logic [7:0]  BAL_ONE          = 8'h01;
	localparam logic [7:0]  BAL_MIN_NEG      = 8'h80;
	localparam logic [7:0]  BAL_MAX_POS      = 8'h7f;
	localparam logic [5:0]  BAL_IO_LIMIT     = 6'h20;
	localparam logic [4:0]  BAL_IO_FLAG_IDX  = 5'h0e;
	localparam logic [7:0]  BAL_IO_W1C_MASK  = 8'hc0;

	// Register map, byte addresses
	localparam logic [11:0] BAL_A_CMD        = 12'h000;
	localparam logic [11:0] BAL_A_SREG       = 12'h004;
	localparam logic [11:0] BAL_A_STAT       = 12'h008;
	localparam logic [4:0]  BAL_WIN_GPR      = 5'h01;
	localparam logic [4:0]  BAL_WIN_IO       = 5'h02;
	localparam int          BAL_STAT_BUSY    = 0;
	localparam int          BAL_STAT_ERR     = 1;
	localparam logic [3:0]  BAL_STRB_ALL     = 4'hf;
	localparam logic [1:0]  BAL_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  BAL_RESP_SLVERR  = 2'h2;

	typedef enum logic [4:0] {
		OP_ADD, OP_ADD_CARRY, OP_SUB, OP_MINUS_CONSTANT, OP_MINUS_WITH_BORROW,
		OP_MINUS_BORROW_CONSTANT, OP_AND, OP_MASK_WITH_CONSTANT, OP_OR,
		OP_MERGE_WITH_CONSTANT, OP_EXCLUSIVE_MERGE, OP_ONES_COMP, OP_TWOS_COMP,
		OP_BIT_SET_IN_REG, OP_BIT_CLEAR_IN_REG, OP_INC, OP_DEC,
		OP_WORD_PLUS_CONSTANT, OP_WORD_MINUS_CONSTANT, OP_IO_BIT_SET, OP_IO_BIT_CLEAR,
		OP_LAST
	} bal_op_e;

	typedef enum {ST_IDLE, ST_FETCH, ST_EXEC, ST_WORD_HI} bal_st_e;

	typedef enum {SEL_NONE, SEL_CMD, SEL_SREG, SEL_STAT, SEL_GPR, SEL_IO} bal_sel_e;

	typedef struct packed {
		logic [5:0] io_addr;
		logic [7:0] imm;
		logic [2:0] bitn;
		logic [4:0] src;
		logic [4:0] dst;
		bal_op_e    op;
	} bal_cmd_s;

	typedef struct packed {
		logic h;
		logic s;
		logic v;
		logic n;
		logic z;
		logic c;
	} bal_flags_s;

	localparam bal_flags_s BAL_FLAGS_RST = '0;
	localparam bal_flags_s BAL_UPD_ARITH = '{h: 1'b1, s: 1'b0, v: 1'b1, n: 1'b1, z: 1'b1, c: 1'b1};
	localparam bal_flags_s BAL_UPD_LOGIC = '{h: 1'b0, s: 1'b0, v: 1'b1, n: 1'b1, z: 1'b1, c: 1'b0};
	localparam bal_flags_s BAL_UPD_COMP  = '{h: 1'b0, s: 1'b0, v: 1'b1, n: 1'b1, z: 1'b1, c: 1'b1};
	localparam bal_flags_s BAL_UPD_WORD  = '{h: 1'b0, s: 1'b1, v: 1'b1, n: 1'b1, z: 1'b1, c: 1'b1};

endpackage

// ===== core/bal_gpr_mem.sv
/*
 * Thirty-two byte working registers, two registered read ports and one write port.
 * Assumes the owner never needs write-through on the same cycle.
 */
`timescale 1ns/1ps
module bal_gpr_mem (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [bal_pkg::BAL_IDX_W-1:0] a_addr,
	output logic      [bal_pkg::BAL_DW-1:0]    a_data,
	input  wire logic [bal_pkg::BAL_IDX_W-1:0] b_addr,
	output logic      [bal_pkg::BAL_DW-1:0]    b_data,
	input  wire logic                          we,
	input  wire logic [bal_pkg::BAL_IDX_W-1:0] waddr,
	input  wire logic [bal_pkg::BAL_DW-1:0]    wdata
);
	import bal_pkg::*;

	logic [BAL_DW-1:0] mem [0:(1<<BAL_IDX_W)-1];

	always_ff @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			a_data <= BAL_ZERO;
			b_data <= BAL_ZERO;
		end else begin
			a_data <= mem[a_addr];
			b_data <= mem[b_addr];
		end
	end

endmodule

// ===== core/bal_io_bank.sv
/*
 * Thirty-two io bytes reachable by the bit set/clear operations and by software.
 * One byte holds peripheral flags; the masked ones clear on a written one.
 * Assumes flag events come from logic on the same clock.
 */
`timescale 1ns/1ps
module bal_io_bank (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [bal_pkg::BAL_IDX_W-1:0] raddr,
	output logic      [bal_pkg::BAL_DW-1:0]    rdata,
	input  wire logic                          we,
	input  wire logic [bal_pkg::BAL_IDX_W-1:0] waddr,
	input  wire logic [bal_pkg::BAL_DW-1:0]    wdata,
	input  wire logic [bal_pkg::BAL_DW-1:0]    evt_set
);
	import bal_pkg::*;

	logic [BAL_DW-1:0] mem [0:(1<<BAL_IDX_W)-1];
	logic [BAL_DW-1:0] flag_r;
	logic              hit;
	logic [BAL_DW-1:0] clr;

	assign hit = we && (waddr == BAL_IO_FLAG_IDX);
	assign clr = hit ? wdata : BAL_ZERO;

	always_ff @(posedge aclk) begin
		if (we && !hit) begin
			mem[waddr] <= wdata;
		end
	end

	// A new event beats a clearing write in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_r <= BAL_ZERO;
		end else begin
			flag_r <= (((flag_r & ~clr) | evt_set) & BAL_IO_W1C_MASK) |
				((hit ? wdata : flag_r) & ~BAL_IO_W1C_MASK);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata <= BAL_ZERO;
		end else begin
			rdata <= (raddr == BAL_IO_FLAG_IDX) ? flag_r : mem[raddr];
		end
	end

	a_w1c_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		(hit && evt_set == BAL_ZERO) |=>
		((flag_r & BAL_IO_W1C_MASK) == ($past(flag_r) & ~$past(wdata) & BAL_IO_W1C_MASK)))
		else $error("io flag not cleared by written one");

endmodule

// ===== test/bal_evt_src.sv
/*
 * Peripheral event source beside the datapath; raises io flag events.
 * Assumes requests arrive on the datapath clock.
 */
`timescale 1ns/1ps
module bal_evt_src (
	input  wire logic       aclk,
	input  wire logic       fire,
	input  wire logic [7:0] mask,
	output logic      [7:0] evt
);
	// One-cycle event, as a real flag source gives it
	always_ff @(posedge aclk) begin
		evt <= fire ? mask : 8'h00;
	end
endmodule

// ===== test/tb_bal_top.sv
/*
 * Self-checking bench: AXI4-Lite master tasks and one task per scenario.
 * Assumes bal_pkg and the core files are compiled first.
 */
`timescale 1ns/1ps
module tb_bal_top;
	import bal_pkg::*;
	logic        aclk, aresetn, aw_v, w_v, ar_v, fire, aw_r, w_r, b_v, ar_r, r_v;
	logic [11:0] aw_a, ar_a;
	logic [31:0] w_d, r_d;
	logic [7:0]  evt, fmask;
	logic [1:0]  b_resp, r_resp;
	int          num_errors, samples_checked;
	initial begin
		aclk = 1'h0;
		forever #2.5 aclk = ~aclk;
	end
	bal_top i_bal_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a), .s_axi_awprot(3'h0),
		.s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
		.s_axi_bready(1'h1), .s_axi_araddr(ar_a), .s_axi_arprot(3'h0), .s_axi_arvalid(ar_v),
		.s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
		.s_axi_rready(1'h1), .io_evt_set(evt));
	bal_evt_src i_bal_evt_src (.aclk(aclk), .fire(fire), .mask(fmask), .evt(evt));
	////////////////////////////////////////////////////////////////////////////
	task complete_run;
		$display("Checked %0d, errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Bounded wait; handshakes are sampled mid-cycle, where they already stand for the coming edge
	task tick(inout int n);
		@(negedge aclk);
		n++;
		if (n > 300) begin
			num_errors++;
			complete_run();
		end
	endtask
	task chk(string nm, logic [31:0] e, logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(logic [11:0] a, logic [31:0] d, logic [1:0] er = BAL_RESP_OKAY);
		int         n;
		logic       s;
		logic [1:0] rs;
		n = 0;
		aw_a <= a; w_d <= d; aw_v <= 1'h1; w_v <= 1'h1;
		do begin
			tick(n);
			s = aw_r & w_r;
			@(posedge aclk);
		end while (s !== 1'h1);
		aw_v <= 1'h0; w_v <= 1'h0;
		do begin
			tick(n);
			s = b_v;
			rs = b_resp;
			@(posedge aclk);
		end while (s !== 1'h1);
		chk("bresp", {30'h0, er}, {30'h0, rs});
	endtask
	task rc(string nm, logic [11:0] a, logic [31:0] e);
		int          n;
		logic        s;
		logic [1:0]  rs;
		logic [31:0] d;
		n = 0;
		ar_a <= a; ar_v <= 1'h1;
		do begin
			tick(n);
			s = ar_r;
			@(posedge aclk);
		end while (s !== 1'h1);
		ar_v <= 1'h0;
		do begin
			tick(n);
			s = r_v;
			rs = r_resp;
			d = r_d;
			@(posedge aclk);
		end while (s !== 1'h1);
		chk(nm, e, d);
		chk("rresp", {30'h0, BAL_RESP_OKAY}, {30'h0, rs});
	endtask
	// One byte command on r4 with r5 as source, then result and flags
	task ex(string nm, bal_op_e o, logic [7:0] k, logic [7:0] er, logic [7:0] es);
		wr(BAL_A_CMD, cm(o, 5'h04, 5'h05, k));
		rc(nm, 12'h090, {24'h0, er});
		rc("sreg", BAL_A_SREG, {24'h0, es});
	endtask
	function automatic logic [31:0] cm(bal_op_e op, logic [4:0] dst, logic [4:0] src, logic [7:0] imm,
		logic [2:0] b = 3'h0, logic [5:0] io = 6'h00);
		bal_cmd_s c;
		c = '{io, imm, b, src, dst, op};
		return c;
	endfunction
	////////////////////////////////////////////////////////////////////////////
	task t_arith;
		wr(12'h084, 32'h0f); wr(12'h088, 32'h01); wr(BAL_A_SREG, 32'h00);
		wr(BAL_A_CMD, cm(OP_ADD, 5'h01, 5'h02, 8'h00));
		rc("add r1", 12'h084, 32'h10);
		rc("add sreg", BAL_A_SREG, 32'h20);
		wr(12'h088, 32'h10); wr(BAL_A_SREG, 32'h01);
		wr(BAL_A_CMD, cm(OP_MINUS_WITH_BORROW, 5'h01, 5'h02, 8'h00));
		rc("sbc r1", 12'h084, 32'hff);
		rc("sbc sreg", BAL_A_SREG, 32'h25);
		$display("arith done");
	endtask
	task t_word;
		wr(12'h0e0, 32'hff); wr(12'h0e4, 32'h7f); wr(BAL_A_SREG, 32'h00);
		wr(BAL_A_CMD, cm(OP_WORD_PLUS_CONSTANT, 5'h18, 5'h00, 8'h01));
		rc("word lo", 12'h0e0, 32'h00);
		rc("word hi", 12'h0e4, 32'h80);
		rc("word sreg", BAL_A_SREG, 32'h0c);
		$display("word done");
	endtask
	task t_clear;
		wr(12'h08c, 32'hf0); wr(BAL_A_SREG, 32'h01);
		wr(BAL_A_CMD, cm(OP_BIT_CLEAR_IN_REG, 5'h03, 5'h00, 8'h90));
		rc("cbr r3", 12'h08c, 32'h60);
		rc("cbr sreg", BAL_A_SREG, 32'h01);
		$display("clear done");
	endtask
	task t_io;
		wr(12'h138, 32'h01);
		fmask <= 8'h80; fire <= 1'h1;
		@(posedge aclk);
		fire <= 1'h0;
		rc("io evt", 12'h138, 32'h81);
		wr(BAL_A_CMD, cm(OP_IO_BIT_SET, 5'h00, 5'h00, 8'h00, 3'h1, 6'h0e));
		rc("io rmw", 12'h138, 32'h03);
		wr(BAL_A_CMD, cm(OP_IO_BIT_SET, 5'h00, 5'h00, 8'h00, 3'h2, 6'h20));
		rc("io far stat", BAL_A_STAT, 32'h02);
		rc("io far", 12'h138, 32'h03);
		wr(BAL_A_CMD, cm(OP_IO_BIT_CLEAR, 5'h00, 5'h00, 8'h00, 3'h0, 6'h0e));
		rc("io clr", 12'h138, 32'h02);
		wr(12'h200, 32'h00, BAL_RESP_SLVERR);
		$display("io done");
	endtask
	task t_ops;
		wr(12'h090, 32'h3c);
		wr(12'h094, 32'h0f);
		wr(BAL_A_SREG, 32'h00);
		ex("sub", OP_SUB, 8'h00, 8'h2d, 8'h20);
		ex("minus_borrow_constant", OP_MINUS_BORROW_CONSTANT, 8'h2d, 8'h00, 8'h02);
		ex("dec", OP_DEC, 8'h00, 8'hff, 8'h04);
		ex("andk", OP_MASK_WITH_CONSTANT, 8'h81, 8'h81, 8'h04);
		ex("and", OP_AND, 8'h00, 8'h01, 8'h00);
		ex("setb", OP_BIT_SET_IN_REG, 8'h80, 8'h81, 8'h04);
		ex("or", OP_OR, 8'h00, 8'h8f, 8'h04);
		ex("com", OP_ONES_COMP, 8'h00, 8'h70, 8'h01);
		ex("addc", OP_ADD_CARRY, 8'h00, 8'h80, 8'h2c);
		ex("neg", OP_TWOS_COMP, 8'h00, 8'h80, 8'h0d);
		ex("xor", OP_EXCLUSIVE_MERGE, 8'h00, 8'h8f, 8'h05);
		ex("subk", OP_MINUS_CONSTANT, 8'h90, 8'hff, 8'h05);
		ex("inc", OP_INC, 8'h00, 8'h00, 8'h03);
		ex("ork", OP_MERGE_WITH_CONSTANT, 8'h7f, 8'h7f, 8'h01);
		wr(BAL_A_CMD, cm(OP_WORD_MINUS_CONSTANT, 5'h18, 5'h00, 8'h01));
		rc("wsub lo", 12'h0e0, 32'hff);
		rc("wsub hi", 12'h0e4, 32'h7f);
		rc("wsub sreg", BAL_A_SREG, 32'h18);
		$display("ops done");
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		aresetn = 1'h0; aw_v = 1'h0; w_v = 1'h0; ar_v = 1'h0; fire = 1'h0; fmask = 8'h00;
		aw_a = 12'h000; ar_a = 12'h000; w_d = 32'h0; num_errors = 0; samples_checked = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_arith;
		t_word;
		t_clear;
		t_io;
		t_ops;
		complete_run;
	end
endmodule
